// File: gps_host_model.sv
// Host model: turns a bench request into one decoded command pulse
`timescale 1ns/100ps
module gps_host_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] id,
  input wire logic [31:0] data,
  input wire logic positioning_busy,
  output gps_pkg::gps_cmd_t cmd,
  output logic serial_activity
);
  logic barred;
  // Settings that must not change mid-positioning are held back by the host
  assign barred = positioning_busy && (id == gps_pkg::CMD_BAUD || id == gps_pkg::CMD_RF_POWER
    || id == gps_pkg::CMD_FREQ_CAL || id == gps_pkg::CMD_TX_MASK);
  initial begin
    cmd = '0;
    serial_activity = 1'h0;
  end
  // Idle fields invert every cycle, alternating between the last word and its inverse
  always @(posedge clk) begin
    cmd.valid <= go && !barred;
    cmd.id <= go ? id : ~cmd.id;
    cmd.data <= go ? data : ~cmd.data;
    serial_activity <= go;
  end
endmodule // gps_host_model

// File: gps_ms_tick.sv
// Millisecond enable pulse divider
`timescale 1ns/100ps
module gps_ms_tick #(
  parameter int CYCLES = gps_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } gps_tick_st_t;
  gps_tick_st_t st_ff;
  gps_tick_st_t nxt_st;
  // One-cycle pulse every CYCLES clocks
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 32'(CYCLES - 1)) begin
      nxt_st.cnt = 32'h00000000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h00000001;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign tick = st_ff.tick;
endmodule // gps_ms_tick

// File: gps_pkg.sv
// Shared constants and carrier types for the RF power sequencer
package gps_pkg;
  // Command identifiers
  localparam logic [7:0] CMD_BAUD = 8'h01;
  localparam logic [7:0] CMD_REF_FREQ = 8'h02;
  localparam logic [7:0] CMD_POWER = 8'h03;
  localparam logic [7:0] CMD_RF_POWER = 8'h05;
  localparam logic [7:0] CMD_FREQ_CAL = 8'h06;
  localparam logic [7:0] CMD_TX_MASK = 8'h07;
  localparam logic [7:0] CMD_SLEEP_TIMER = 8'h12;
  localparam logic [7:0] CMD_DOPPLER = 8'h57;
  localparam logic [7:0] CMD_FLOW_POINT = 8'h7F;
  localparam logic [7:0] NOTICE_DONE = 8'h7F;
  // Reset values
  localparam logic [31:0] REF_FREQ_RST = 32'h00E10000;
  localparam logic [15:0] DOPPLER_RST = 16'h0168;
  localparam logic [2:0] BAUD_RST = 3'h2;
  localparam logic [23:0] SLEEP_RST = 24'h000000;
  // Baud selector: 0..6 = 2400,4800,9600,19200,38400,57600,115200
  localparam logic [2:0] BAUD_MAX = 3'h6;
  // Power-control data field
  localparam logic [1:0] PWR_RUN = 2'h0;
  localparam logic [1:0] PWR_HALT = 2'h1;
  localparam logic [1:0] PWR_STOP = 2'h2;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int SAMPLE_DIV = 2;
  // Command carrier from the serial front end
  typedef struct packed {
    logic valid;
    logic [7:0] id;
    logic [31:0] data;
  } gps_cmd_t;
  // Settings held by the block
  typedef struct packed {
    logic freq_cal_en;
    logic [31:0] ref_freq;
    logic [15:0] doppler;
    logic [2:0] baud;
    logic [2:0] baud_pend;
    logic baud_pend_vld;
    logic tx_mask_en;
    logic flow_point_en;
    logic [23:0] sleep_ms;
    logic sleep_stop;
  } gps_cfg_t;
endpackage

// File: gps_rf_power_sequencer.sv
// RF power sequencing, sample masking and power-save control
// Summary of operation
// R1: Positioning start enables sample clock, RF power high and feedback outputs.
// R2: Status reports capture in progress while capture window runs.
// R3: Status reports idling once the capture window ends.
// R4: After reception, sample clock stops, RF power low, feedback outputs stop.
// R5: On completion send notice 0x7F only when flow point output enabled.
// R6: Flow point output disabled after reset.
// R7: Host must not send baud, RF power, calibration or mask commands mid-run.
// R8: Command 0x06 sets calibration enable and reports the setting back.
// R9: Host keeps reference clock running through calibrated capture windows.
// R10: Reference frequency held as 4 bytes, reset 0x00E10000.
// R11: Doppler search range held in hertz, reset 0x168.
// R12: Seven serial rates supported, 9600 bps after reset.
// R13: Baud change during another reception applies after that reception ends.
// R14: Mask off by default; when masking and transmit active, samples read zero.
// R15: While masking on transmit active, gain and offset outputs go high impedance.
// R16: RF power is controlled autonomously during positioning.
// R17: Power command or sleep timer expiry leaves run for a sleep mode.
// R18: Light sleep keeps PLL; wake low or any command returns to run.
// R19: Deep sleep stops PLL; only wake low returns to run.
// R20: Sleep command drives RF power low, then standby low, then enters mode.
// R21: Idle for programmed timeout enters the preselected sleep mode.
// R22: Timeout is 24-bit milliseconds; zero disables automatic sleep.
// R23: Wake input is active low.
// R24: Leaving sleep raises standby before run resumes.
`timescale 1ns/100ps
module gps_rf_power_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire gps_pkg::gps_cmd_t cmd_in,
  input wire logic cmd_rx_busy,
  input wire logic serial_activity,
  input wire logic positioning_request,
  input wire logic [15:0] capture_len,
  input wire logic positioning_done,
  input wire logic transmit_active_in,
  input wire logic [3:0] adc_sample_in,
  input wire logic wake_in_n,
  output logic sample_clock_out,
  output logic rf_power_out,
  output logic gain_feedback_out,
  output logic gain_feedback_oe_n,
  output logic offset_feedback_out,
  output logic offset_feedback_oe_n,
  output logic [3:0] adc_sample_out,
  output logic capture_busy,
  output logic positioning_busy,
  output logic notice_valid,
  output logic [7:0] notice_id,
  output logic reply_valid,
  output logic [7:0] reply_id,
  output logic [31:0] reply_data,
  output logic [2:0] baud_sel,
  output logic [31:0] ref_freq,
  output logic [15:0] doppler_range,
  output logic freq_cal_en,
  output logic pll_run,
  output logic standby_out_n
);
  typedef enum logic [5:0] {
    GPS_RUN = 6'h01,
    GPS_RF_OFF = 6'h02,
    GPS_STBY = 6'h04,
    GPS_HALT = 6'h08,
    GPS_STOP = 6'h10,
    GPS_WAKE = 6'h20
  } gps_pwr_t;
  typedef enum logic [3:0] {
    GPS_IDLE = 4'h1,
    GPS_CAPTURE = 4'h2,
    GPS_PROCESS = 4'h4,
    GPS_FINISH = 4'h8
  } gps_pos_t;
  typedef struct packed {
    gps_pwr_t pwr;
    gps_pos_t pos;
    logic target_stop;
    logic [15:0] cap_cnt;
    logic [23:0] idle_ms;
    logic [7:0] div_cnt;
    gps_pkg::gps_cfg_t cfg;
    logic sample_clk;
    logic rf_on;
    logic gain;
    logic gain_oe_n;
    logic offset;
    logic offset_oe_n;
    logic [3:0] sample;
    logic notice_v;
    logic reply_v;
    logic [7:0] reply_id;
    logic [31:0] reply_data;
    logic stby_n;
    logic cap_busy;
    logic pos_busy;
    logic pll_on;
  } gps_st_t;

  gps_st_t st_ff;
  gps_st_t nxt_st;
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic wake_n;
  logic ms_tick;
  logic [3:0] masked;
  logic masking;
  logic feedback_on;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Wake pin is asynchronous and idles high
  gps_sync #(
    .RST_VAL(1'b1)
  ) u_wake_sync (
    .clk(clk),
    .rst_n(rst_sync_ff),
    .din(wake_in_n),
    .dout(wake_n)
  );

  gps_ms_tick #(
    .CYCLES(gps_pkg::MS_CYCLES)
  ) u_ms_tick (
    .clk(clk),
    .rst_n(rst_sync_ff),
    .tick(ms_tick)
  );

  // Gain feedback from the sample magnitude band
  function automatic logic gain_of(input logic [3:0] s);
    gain_of = (s >= 4'h6) && (s <= 4'hA);
  endfunction

  // Sample masking; transmit pin is assumed on the clock domain of the RF front end
  assign masking = st_ff.cfg.tx_mask_en && transmit_active_in; // R14
  assign masked = masking ? 4'h0 : adc_sample_in; // R14
  assign feedback_on = st_ff.rf_on && (st_ff.pos == GPS_CAPTURE);

  // Next-state logic for sequencing, settings and power save
  always_comb begin
    nxt_st = st_ff;
    nxt_st.notice_v = 1'b0;
    nxt_st.reply_v = 1'b0;
    nxt_st.sample = masked;

    // Baud change deferred while another command is still arriving
    if (st_ff.cfg.baud_pend_vld && !cmd_rx_busy) begin
      nxt_st.cfg.baud = st_ff.cfg.baud_pend; // R13
      nxt_st.cfg.baud_pend_vld = 1'b0;
    end

    // Commands are honoured only in run; a light-sleep wake drops the command
    if (cmd_in.valid && (st_ff.pwr == GPS_RUN)) begin
      case (cmd_in.id)
        gps_pkg::CMD_BAUD: begin
          if (cmd_in.data[2:0] <= gps_pkg::BAUD_MAX) begin // R12
            if (cmd_rx_busy) begin
              nxt_st.cfg.baud_pend = cmd_in.data[2:0]; // R13
              nxt_st.cfg.baud_pend_vld = 1'b1;
            end else begin
              nxt_st.cfg.baud = cmd_in.data[2:0];
            end
          end
        end
        gps_pkg::CMD_REF_FREQ: begin
          nxt_st.cfg.ref_freq = cmd_in.data; // R10
        end
        gps_pkg::CMD_FREQ_CAL: begin
          nxt_st.cfg.freq_cal_en = cmd_in.data[0]; // R8
          nxt_st.reply_v = 1'b1;
          nxt_st.reply_id = gps_pkg::CMD_FREQ_CAL;
          nxt_st.reply_data = {31'h00000000, cmd_in.data[0]};
        end
        gps_pkg::CMD_TX_MASK: begin
          nxt_st.cfg.tx_mask_en = cmd_in.data[0];
        end
        gps_pkg::CMD_DOPPLER: begin
          nxt_st.cfg.doppler = cmd_in.data[15:0]; // R11
        end
        gps_pkg::CMD_FLOW_POINT: begin
          nxt_st.cfg.flow_point_en = cmd_in.data[0];
        end
        gps_pkg::CMD_SLEEP_TIMER: begin
          nxt_st.cfg.sleep_ms = cmd_in.data[23:0]; // R22
          nxt_st.cfg.sleep_stop = cmd_in.data[24];
        end
        gps_pkg::CMD_RF_POWER: begin
          // Manual RF control ignored while positioning runs
          if (st_ff.pos == GPS_IDLE) begin // R16
            nxt_st.rf_on = cmd_in.data[0];
          end
        end
        default: begin
        end
      endcase
    end

    // Positioning sequence
    case (st_ff.pos)
      GPS_IDLE: begin
        if (positioning_request && (st_ff.pwr == GPS_RUN)) begin
          nxt_st.pos = GPS_CAPTURE;
          nxt_st.rf_on = 1'b1; // R1
          nxt_st.cap_cnt = capture_len;
        end
      end
      GPS_CAPTURE: begin
        if (st_ff.cap_cnt == 16'h0000) begin
          nxt_st.pos = GPS_PROCESS; // R3
          nxt_st.rf_on = 1'b0; // R4
        end else if (ms_tick) begin
          nxt_st.cap_cnt = st_ff.cap_cnt - 16'h0001;
        end
      end
      GPS_PROCESS: begin
        if (positioning_done) begin
          nxt_st.pos = GPS_FINISH;
        end
      end
      GPS_FINISH: begin
        nxt_st.notice_v = st_ff.cfg.flow_point_en; // R5
        nxt_st.pos = GPS_IDLE;
      end
      default: begin
        nxt_st.pos = GPS_IDLE;
      end
    endcase

    // Sample clock divider runs only while RF power is on in capture
    if (feedback_on) begin // R1
      if (st_ff.div_cnt == 8'(gps_pkg::SAMPLE_DIV - 1)) begin
        nxt_st.div_cnt = 8'h00;
        nxt_st.sample_clk = !st_ff.sample_clk;
      end else begin
        nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
      end
    end else begin
      nxt_st.div_cnt = 8'h00;
      nxt_st.sample_clk = 1'b0; // R4
    end

    // Feedback outputs: driven in capture, released when masked or stopped
    if (!feedback_on || masking) begin // R4 R15
      nxt_st.gain_oe_n = 1'b1;
      nxt_st.offset_oe_n = 1'b1;
      nxt_st.gain = 1'b0;
      nxt_st.offset = 1'b0;
    end else begin
      nxt_st.gain = gain_of(masked);
      nxt_st.gain_oe_n = 1'b0;
      nxt_st.offset = masked[3];
      // Mid-scale sample leaves the offset line floating
      nxt_st.offset_oe_n = (masked == 4'h8);
    end

    // Idle timer counts whole milliseconds without activity
    if ((st_ff.pos != GPS_IDLE) || cmd_in.valid || serial_activity || cmd_rx_busy
        || (st_ff.pwr != GPS_RUN)) begin
      nxt_st.idle_ms = 24'h000000; // R21
    end else if (ms_tick && (st_ff.idle_ms != 24'hFFFFFF)) begin
      nxt_st.idle_ms = st_ff.idle_ms + 24'h000001;
    end

    // Power-save sequencing
    case (st_ff.pwr)
      GPS_RUN: begin
        if (cmd_in.valid && (cmd_in.id == gps_pkg::CMD_POWER)
            && (cmd_in.data[1:0] != gps_pkg::PWR_RUN)) begin
          nxt_st.pwr = GPS_RF_OFF; // R17
          nxt_st.target_stop = (cmd_in.data[1:0] == gps_pkg::PWR_STOP);
        end else if ((st_ff.cfg.sleep_ms != 24'h000000) // R22
                     && (st_ff.idle_ms >= st_ff.cfg.sleep_ms)) begin
          nxt_st.pwr = GPS_RF_OFF; // R21
          nxt_st.target_stop = st_ff.cfg.sleep_stop;
        end
      end
      GPS_RF_OFF: begin
        nxt_st.rf_on = 1'b0; // R20
        nxt_st.pos = GPS_IDLE;
        nxt_st.pwr = GPS_STBY;
      end
      GPS_STBY: begin
        nxt_st.stby_n = 1'b0; // R20
        nxt_st.pwr = st_ff.target_stop ? GPS_STOP : GPS_HALT;
      end
      GPS_HALT: begin
        if (!wake_n || cmd_in.valid) begin // R18 R23
          nxt_st.pwr = GPS_WAKE;
        end
      end
      GPS_STOP: begin
        if (!wake_n) begin // R19 R23
          nxt_st.pwr = GPS_WAKE;
        end
      end
      GPS_WAKE: begin
        nxt_st.stby_n = 1'b1; // R24
        nxt_st.pwr = GPS_RUN;
      end
      default: begin
        nxt_st.pwr = GPS_RUN;
      end
    endcase

    // Status flags taken from the next state, so the outputs leave flops
    nxt_st.cap_busy = (nxt_st.pos == GPS_CAPTURE); // R2
    nxt_st.pos_busy = (nxt_st.pos != GPS_IDLE);
    nxt_st.pll_on = (nxt_st.pwr != GPS_STOP); // R18 R19
  end

  // State register; settings return to their defaults on reset
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= '0;
      st_ff.pwr <= GPS_RUN;
      st_ff.pos <= GPS_IDLE;
      st_ff.cfg.ref_freq <= gps_pkg::REF_FREQ_RST; // R10
      st_ff.cfg.doppler <= gps_pkg::DOPPLER_RST; // R11
      st_ff.cfg.baud <= gps_pkg::BAUD_RST; // R12
      st_ff.cfg.sleep_ms <= gps_pkg::SLEEP_RST;
      st_ff.cfg.flow_point_en <= 1'b0; // R6
      st_ff.cfg.tx_mask_en <= 1'b0; // R14
      st_ff.gain_oe_n <= 1'b1;
      st_ff.offset_oe_n <= 1'b1;
      st_ff.stby_n <= 1'b1;
      st_ff.pll_on <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from state flops; notice_id is a constant
  assign sample_clock_out = st_ff.sample_clk;
  assign rf_power_out = st_ff.rf_on;
  assign gain_feedback_out = st_ff.gain;
  assign gain_feedback_oe_n = st_ff.gain_oe_n;
  assign offset_feedback_out = st_ff.offset;
  assign offset_feedback_oe_n = st_ff.offset_oe_n;
  assign adc_sample_out = st_ff.sample;
  assign capture_busy = st_ff.cap_busy; // R2
  assign positioning_busy = st_ff.pos_busy;
  assign notice_valid = st_ff.notice_v;
  assign notice_id = gps_pkg::NOTICE_DONE;
  assign reply_valid = st_ff.reply_v;
  assign reply_id = st_ff.reply_id;
  assign reply_data = st_ff.reply_data;
  assign baud_sel = st_ff.cfg.baud;
  assign ref_freq = st_ff.cfg.ref_freq;
  assign doppler_range = st_ff.cfg.doppler;
  assign freq_cal_en = st_ff.cfg.freq_cal_en; // R9
  assign pll_run = st_ff.pll_on; // R18 R19
  assign standby_out_n = st_ff.stby_n;
endmodule // gps_rf_power_sequencer

// File: gps_seq_props.sv
// Concurrent checks on the ports of the RF power sequencer
`timescale 1ns/100ps
module gps_seq_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire gps_pkg::gps_cmd_t cmd_in,
  input wire logic cmd_rx_busy,
  input wire logic positioning_done,
  input wire logic transmit_active_in,
  input wire logic [3:0] adc_sample_in,
  input wire logic wake_in_n,
  input wire logic rf_power_out,
  input wire logic gain_feedback_oe_n,
  input wire logic offset_feedback_oe_n,
  input wire logic [3:0] adc_sample_out,
  input wire logic capture_busy,
  input wire logic positioning_busy,
  input wire logic notice_valid,
  input wire logic [7:0] notice_id,
  input wire logic reply_valid,
  input wire logic [31:0] reply_data,
  input wire logic [2:0] baud_sel,
  input wire logic pll_run,
  input wire logic standby_out_n
);
  logic [2:0] set_ff; // Flow point, transmit mask, calibration
  logic run_cmd;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Commands count only in run and outside positioning
  assign run_cmd = cmd_in.valid && standby_out_n && !positioning_busy;
  // Shadow enables, so no check needs internal state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      set_ff <= 3'h0;
    end else if (run_cmd) begin
      if (cmd_in.id == gps_pkg::CMD_FLOW_POINT) set_ff[2] <= cmd_in.data[0];
      if (cmd_in.id == gps_pkg::CMD_TX_MASK) set_ff[1] <= cmd_in.data[0];
      if (cmd_in.id == gps_pkg::CMD_FREQ_CAL) set_ff[0] <= cmd_in.data[0];
    end
  end
  // Internal reset lags the pin, so the sample path is judged a few edges later
  unmask_pass_a: assert property ($past(rst_n, 4) && !(set_ff[1] && transmit_active_in)
    |=> adc_sample_out == $past(adc_sample_in)) else $error("unmasked sample differs");
  mask_zero_a: assert property (set_ff[1] && transmit_active_in |=> adc_sample_out == 4'h0)
    else $error("masked sample not zero");
  feedback_hiz_a: assert property (set_ff[1] && transmit_active_in && capture_busy
    |=> gain_feedback_oe_n && offset_feedback_oe_n) else $error("feedback driven in mask");
  rf_on_a: assert property ($rose(capture_busy) |-> ##[0:2] rf_power_out)
    else $error("rf power off in capture");
  rf_off_a: assert property ($fell(capture_busy) |-> ##[0:2] (!rf_power_out
    && gain_feedback_oe_n && offset_feedback_oe_n)) else $error("rf block left on");
  notice_gate_a: assert property (notice_valid |-> set_ff[2] && $past(positioning_done, 2)
    && notice_id == gps_pkg::NOTICE_DONE) else $error("unexpected notice");
  cal_reply_a: assert property (run_cmd && cmd_in.id == gps_pkg::CMD_FREQ_CAL
    |-> ##[1:2] (reply_valid && reply_data[0] == set_ff[0])) else $error("calibration reply");
  baud_hold_a: assert property (cmd_rx_busy && $past(cmd_rx_busy) |-> $stable(baud_sel))
    else $error("baud changed mid reception");
  sleep_order_a: assert property ($fell(standby_out_n) |-> !$past(rf_power_out))
    else $error("standby before rf off");
  deep_pll_a: assert property (!pll_run |-> !standby_out_n)
    else $error("pll stopped in run");
  halt_cmd_a: assert property (!standby_out_n && pll_run && cmd_in.valid
    |-> ##[1:4] standby_out_n) else $error("no command wake");
  pin_wake_a: assert property ((!standby_out_n && !wake_in_n) [*4] |-> ##[0:6] standby_out_n)
    else $error("no pin wake");
endmodule // gps_seq_props

bind gps_rf_power_sequencer gps_seq_props gps_seq_props_i (.clk, .rst_n, .cmd_in, .cmd_rx_busy,
  .positioning_done, .transmit_active_in, .adc_sample_in, .wake_in_n, .rf_power_out,
  .gain_feedback_oe_n, .offset_feedback_oe_n, .adc_sample_out, .capture_busy,
  .positioning_busy, .notice_valid, .notice_id, .reply_valid, .reply_data, .baud_sel,
  .pll_run, .standby_out_n);

// File: gps_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module gps_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic [2:0] stage;
    logic value;
  } gps_sync_st_t;
  gps_sync_st_t st_ff;
  gps_sync_st_t nxt_st;
  // Only stages two and three are compared; stage one feeds stage two only
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage = {st_ff.stage[1:0], din};
    if (st_ff.stage[1] == st_ff.stage[2]) begin
      nxt_st.value = st_ff.stage[2];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= {{3{RST_VAL}}, RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign dout = st_ff.value;
endmodule // gps_sync

// File: tb_gps_rf_power_sequencer.sv
// Self-checking bench for the RF power sequencer with a host model
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
`define WAIT(s, v) begin k = 0; while ((s) !== (v) && k < 45000) begin @(posedge clk); \
  k++; end #1; end
module tb_gps_rf_power_sequencer;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic go = 1'h0;
  logic [7:0] id = 8'h00;
  logic [31:0] data = 32'h0;
  logic cmd_rx_busy = 1'h0, positioning_request = 1'h0, positioning_done = 1'h0;
  logic transmit_active_in = 1'h0, wake_in_n = 1'h1;
  logic [3:0] adc_sample_in = 4'h0;
  logic [15:0] capture_len = 16'h0001; // One-millisecond window keeps the run brief
  gps_pkg::gps_cmd_t cmd_in;
  logic serial_activity, sample_clock_out, rf_power_out, gain_feedback_out, gain_feedback_oe_n;
  logic offset_feedback_out, offset_feedback_oe_n, capture_busy, positioning_busy, notice_valid;
  logic reply_valid, freq_cal_en, pll_run, standby_out_n;
  logic [3:0] adc_sample_out;
  logic [7:0] notice_id, reply_id;
  logic [31:0] reply_data, ref_freq;
  logic [39:0] last_reply;
  logic [2:0] baud_sel;
  logic [15:0] doppler_range;
  int errors = 0, tests_run = 0, k = 0, replies = 0, notices = 0;

  always #12.5 clk = ~clk;

  gps_host_model gps_host_model_i (.clk, .go, .id, .data, .positioning_busy, .cmd(cmd_in),
    .serial_activity);
  gps_rf_power_sequencer gps_rf_power_sequencer_i (.clk, .rst_n, .cmd_in, .cmd_rx_busy,
    .serial_activity, .positioning_request, .capture_len, .positioning_done,
    .transmit_active_in, .adc_sample_in, .wake_in_n, .sample_clock_out, .rf_power_out,
    .gain_feedback_out, .gain_feedback_oe_n, .offset_feedback_out, .offset_feedback_oe_n,
    .adc_sample_out, .capture_busy, .positioning_busy, .notice_valid, .notice_id, .reply_valid,
    .reply_id, .reply_data, .baud_sel, .ref_freq, .doppler_range, .freq_cal_en, .pll_run,
    .standby_out_n);

  // Replies and notices last one cycle, so every edge is watched
  always @(posedge clk) begin
    if (reply_valid === 1'h1) begin
      replies++;
      last_reply = {reply_id, reply_data};
    end
    if (notice_valid === 1'h1) notices++;
  end

  // One host command, then time for the setting to land
  task automatic send(input logic [7:0] i, input logic [31:0] d);
    @(posedge clk);
    go <= 1'h1;
    id <= i;
    data <= d;
    @(posedge clk);
    go <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // One positioning pass: masked capture, feedback table, then processing end
  task automatic capture();
    logic s;
    @(posedge clk);
    positioning_request <= 1'h1;
    transmit_active_in <= 1'h1;
    adc_sample_in <= 4'hF;
    @(posedge clk);
    positioning_request <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("rf_on", 1'h1, rf_power_out)
    `CHK("capture", 1'h1, capture_busy)
    `CHK("pos_busy", 1'h1, positioning_busy)
    `CHK("cal_kept", 1'h1, freq_cal_en)
    `CHK("gain_hiz", 1'h1, gain_feedback_oe_n)
    `CHK("offset_hiz", 1'h1, offset_feedback_oe_n)
    send(gps_pkg::CMD_TX_MASK, 32'h0);
    `CHK("still_masked", 4'h0, adc_sample_out)
    s = sample_clock_out;
    repeat (2) @(posedge clk);
    #1;
    `CHK("sample_clk", ~s, sample_clock_out)
    for (int v = 0; v < 16; v++) begin
      @(posedge clk);
      transmit_active_in <= 1'h0;
      adc_sample_in <= v[3:0];
      repeat (2) @(posedge clk);
      #1;
      `CHK("gain", (v >= 6 && v <= 10), gain_feedback_out)
      `CHK("gain_oe", 1'h0, gain_feedback_oe_n)
      `CHK("offset_oe", (v == 8), offset_feedback_oe_n)
      if (v != 8) `CHK("offset", (v > 8), offset_feedback_out)
    end
    `WAIT(capture_busy, 1'h0)
    `CHK("idle", 1'h0, capture_busy)
    `CHK("rf_off", 1'h0, rf_power_out)
    `CHK("gain_off", 1'h1, gain_feedback_oe_n)
    `CHK("offset_off", 1'h1, offset_feedback_oe_n)
    s = sample_clock_out;
    repeat (4) @(posedge clk);
    #1;
    `CHK("sample_stop", s, sample_clock_out)
    @(posedge clk);
    positioning_done <= 1'h1;
    @(posedge clk);
    positioning_done <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    `CHK("pos_idle", 1'h0, positioning_busy)
  endtask

  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Three one-millisecond waits dominate; the limit leaves ample margin
  initial begin
    repeat (150000) @(posedge clk);
    errors++;
    give_verdict();
  end

  // Main sequence: defaults, settings, two positioning passes, both sleeps
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    #1;
    `CHK("baud_rst", gps_pkg::BAUD_RST, baud_sel)
    `CHK("ref_rst", gps_pkg::REF_FREQ_RST, ref_freq)
    `CHK("dop_rst", gps_pkg::DOPPLER_RST, doppler_range)
    `CHK("cal_rst", 1'h0, freq_cal_en)
    @(posedge clk);
    transmit_active_in <= 1'h1;
    adc_sample_in <= 4'h5;
    repeat (2) @(posedge clk);
    #1;
    `CHK("unmasked", 4'h5, adc_sample_out)
    for (int b = 0; b < 7; b++) begin
      send(gps_pkg::CMD_BAUD, b);
      `CHK("baud", b[2:0], baud_sel)
    end
    send(gps_pkg::CMD_BAUD, 32'h7);
    `CHK("baud_bad", 3'h6, baud_sel)
    @(posedge clk);
    cmd_rx_busy <= 1'h1;
    send(gps_pkg::CMD_BAUD, 32'h4);
    `CHK("baud_held", 3'h6, baud_sel)
    @(posedge clk);
    cmd_rx_busy <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("baud_late", 3'h4, baud_sel)
    send(gps_pkg::CMD_REF_FREQ, 32'hA5C31E0F);
    `CHK("ref", 32'hA5C31E0F, ref_freq)
    send(gps_pkg::CMD_DOPPLER, 32'h216);
    `CHK("dop", 16'h0216, doppler_range)
    send(gps_pkg::CMD_FREQ_CAL, 32'h1);
    `CHK("cal", 1'h1, freq_cal_en)
    `CHK("replies", 1, replies)
    `CHK("reply_bit", 1'h1, last_reply[0])
    `CHK("reply_id", gps_pkg::CMD_FREQ_CAL, last_reply[39:32])
    send(gps_pkg::CMD_RF_POWER, 32'h1);
    `CHK("rf_manual", 1'h1, rf_power_out)
    send(gps_pkg::CMD_RF_POWER, 32'h0);
    `CHK("rf_manual_off", 1'h0, rf_power_out)
    send(gps_pkg::CMD_TX_MASK, 32'h1);
    `CHK("masked", 4'h0, adc_sample_out)
    capture();
    `CHK("no_notice", 0, notices)
    send(gps_pkg::CMD_FLOW_POINT, 32'h1);
    capture();
    `CHK("notice", 1, notices)
    `CHK("notice_id", gps_pkg::NOTICE_DONE, notice_id)
    send(gps_pkg::CMD_POWER, 32'h1);
    `WAIT(standby_out_n, 1'h0)
    `CHK("halt", 1'h0, standby_out_n)
    `CHK("rf_sleep", 1'h0, rf_power_out)
    `CHK("pll_halt", 1'h1, pll_run)
    send(gps_pkg::CMD_DOPPLER, 32'h168);
    `WAIT(standby_out_n, 1'h1)
    `CHK("cmd_wake", 1'h1, standby_out_n)
    send(gps_pkg::CMD_POWER, 32'h2);
    `WAIT(standby_out_n, 1'h0)
    `CHK("pll_stop", 1'h0, pll_run)
    send(gps_pkg::CMD_DOPPLER, 32'h168);
    repeat (10) @(posedge clk);
    #1;
    `CHK("deep_stays", 1'h0, standby_out_n)
    @(posedge clk);
    wake_in_n <= 1'h0;
    `WAIT(standby_out_n, 1'h1)
    `CHK("pin_wake", 1'h1, standby_out_n)
    `CHK("pll_back", 1'h1, pll_run)
    @(posedge clk);
    wake_in_n <= 1'h1;
    send(gps_pkg::CMD_POWER, 32'h0);
    `CHK("run_kept", 1'h1, standby_out_n)
    // Deep sleep after one idle millisecond, then the pin brings it back
    send(gps_pkg::CMD_SLEEP_TIMER, 32'h01000001);
    `CHK("timer_armed", 1'h1, standby_out_n)
    `WAIT(standby_out_n, 1'h0)
    `CHK("timer_sleep", 1'h0, standby_out_n)
    `CHK("timer_deep", 1'h0, pll_run)
    @(posedge clk);
    wake_in_n <= 1'h0;
    `WAIT(standby_out_n, 1'h1)
    `CHK("timer_wake", 1'h1, standby_out_n)
    @(posedge clk);
    wake_in_n <= 1'h1;
    give_verdict();
  end
endmodule // tb_gps_rf_power_sequencer
